//--- hdl/ivs_pkg.sv
// Package with vector map, priority encoding, memory window and stacking constants.
package ivs_pkg;
  localparam logic [15:0] VEC_RESET     = 16'hfffe;
  localparam logic [15:0] VEC_SWTRAP    = 16'hfffc;
  localparam logic [15:0] VEC_EXT       = 16'hfffa;
  localparam logic [15:0] VEC_TCH0      = 16'hfff6;
  localparam logic [15:0] VEC_TCH1      = 16'hfff4;
  localparam logic [15:0] VEC_TOVF      = 16'hfff2;
  localparam logic [15:0] VEC_KBD       = 16'hffe0;
  localparam logic [15:0] VEC_ADC       = 16'hffde;
  localparam logic [15:0] RAM_LO        = 16'h0080;
  localparam logic [15:0] RAM_HI        = 16'h00ff;
  localparam logic [15:0] SP_RESET      = 16'h00ff;
  localparam logic [2:0]  INT_BYTES     = 3'h5;
  localparam logic [2:0]  CALL_BYTES    = 3'h2;
  localparam int          NSRC          = 8;
  // Source index order is priority order, index 0 highest.
  localparam int          SRC_RESET     = 0;
  localparam int          SRC_SWTRAP    = 1;
  localparam int          SRC_EXT       = 2;
  localparam int          SRC_TCH0      = 3;
  localparam int          SRC_TCH1      = 4;
  localparam int          SRC_TOVF      = 5;
  localparam int          SRC_KBD       = 6;
  localparam int          SRC_ADC       = 7;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PUSH  = 3'h1,
    ST_VECHI = 3'h3,
    ST_VECLO = 3'h2,
    ST_PULL  = 3'h6
  } ivs_state_type;

  function automatic logic [15:0] vec_base(input logic [2:0] idx);
    unique case (idx)
      3'h0: vec_base = VEC_RESET;
      3'h1: vec_base = VEC_SWTRAP;
      3'h2: vec_base = VEC_EXT;
      3'h3: vec_base = VEC_TCH0;
      3'h4: vec_base = VEC_TCH1;
      3'h5: vec_base = VEC_TOVF;
      3'h6: vec_base = VEC_KBD;
      default: vec_base = VEC_ADC;
    endcase
  endfunction : vec_base
endpackage : ivs_pkg

//--- hdl/ivs_arb_if.sv
// Interface carrying the arbitration result from the priority encoder to the sequencer.
`timescale 1ns/1ps
`default_nettype none
interface ivs_arb_if;
  logic       any;
  logic [2:0] idx;
  modport enc (output any, output idx);
  modport seq (input any, input idx);
endinterface : ivs_arb_if
`default_nettype wire

//--- hdl/ivs_prio.sv
// Fixed-priority encoder over the pending interrupt sources.
`timescale 1ns/1ps
`default_nettype none
module ivs_prio (
  input  wire logic [7:0] req,
  ivs_arb_if.enc          arb
);
  // Lowest index wins; unused vector slots have no request line at all.
  always_comb begin
    arb.any = |req;
    arb.idx = 3'h0;
    for (int i = ivs_pkg::NSRC - 1; i >= 0; i--) begin
      if (req[i]) begin
        arb.idx = 3'(i);
      end
    end
  end
endmodule : ivs_prio
`default_nettype wire

//--- hdl/ivs_unit.sv
// Interrupt vectoring and stack pointer sequencer of the core.
// How it works
// - Each source reads its two vector bytes from its own fixed address pair.
// - Timer channel 1 vectors at fff4/fff5, channel 0 at fff6/fff7.
// - Reset wins, then trap, pin, channel 0, channel 1, overflow, keyboard, converter.
// - Addresses 0080 to 00ff are on-chip RAM; stack location is programmable.
// - The stack pointer is sixteen bits and reaches the whole address space.
// - Interrupt entry other than reset pushes exactly five bytes before the vector fetch; reset pushes none.
// - The upper index register is never stacked by interrupt entry.
// - A call pushes two return bytes; a return pulls two.
// - Stack pointer decrements per push and increments per pull.
`timescale 1ns/1ps
`default_nettype none
module ivs_unit (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  irq_req,
  input  wire logic        int_enable,
  input  wire logic        call_start,
  input  wire logic        ret_start,
  input  wire logic        sp_load,
  input  wire logic [15:0] sp_load_val,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [15:0] cpu_addr,
  output logic             busy,
  output logic [15:0]      mem_addr,
  output logic             mem_wr,
  output logic             mem_rd,
  output logic [2:0]       push_index,
  output logic [15:0]      stack_ptr,
  output logic [15:0]      new_pc,
  output logic             pc_load,
  output logic [2:0]       ack_index,
  output logic             int_ack,
  output logic             ram_sel
);
  typedef struct packed {
    ivs_pkg::ivs_state_type st;
    logic [15:0]            sp;
    logic [2:0]             cnt;
    logic [2:0]             src;
    logic [15:0]            vaddr;
    logic [7:0]             vhi;
    logic [15:0]            pc;
    logic                   pcl;
    logic                   ack;
    logic [15:0]            addr;
    logic                   wr;
    logic                   rd;
  } ivs_regs_type;

  ivs_regs_type state_reg;
  ivs_regs_type state_next;
  ivs_arb_if    arb ();

  // Stack arithmetic wraps at the ends of the address space; software keeps it inside RAM.
  function automatic logic [15:0] sp_dec(input logic [15:0] v);
    sp_dec = v - 16'h0001;
  endfunction : sp_dec

  function automatic logic [15:0] sp_inc(input logic [15:0] v);
    sp_inc = v + 16'h0001;
  endfunction : sp_inc

  // Reset is never masked, so it bypasses the global enable.
  logic [7:0] gated_req;
  assign gated_req = int_enable ? irq_req : (irq_req & 8'h01);

  ivs_prio u_prio (
    .req (gated_req),
    .arb (arb)
  );

  always_comb begin
    state_next     = state_reg;
    state_next.pcl = 1'b0;
    state_next.ack = 1'b0;
    state_next.wr  = 1'b0;
    state_next.rd  = 1'b0;
    unique case (state_reg.st)
      ivs_pkg::ST_IDLE: begin
        if (sp_load) begin
          state_next.sp = sp_load_val;
        end else if (arb.any) begin
          state_next.src   = arb.idx;
          state_next.vaddr = ivs_pkg::vec_base(arb.idx);
          // Reset restarts the core, so nothing is worth stacking.
          if (arb.idx == 3'h0) begin
            state_next.sp = ivs_pkg::SP_RESET;
            state_next.st = ivs_pkg::ST_VECHI;
          end else begin
            state_next.cnt = ivs_pkg::INT_BYTES;
            state_next.st  = ivs_pkg::ST_PUSH;
          end
        end else if (call_start) begin
          state_next.cnt = ivs_pkg::CALL_BYTES;
          state_next.src = 3'h0;
          state_next.st  = ivs_pkg::ST_PUSH;
        end else if (ret_start) begin
          state_next.cnt = ivs_pkg::CALL_BYTES;
          state_next.st  = ivs_pkg::ST_PULL;
        end
      end
      ivs_pkg::ST_PUSH: begin
        state_next.addr = state_reg.sp;
        state_next.wr   = 1'b1;
        state_next.sp   = sp_dec(state_reg.sp);
        state_next.cnt  = state_reg.cnt - 3'h1;
        if (state_reg.cnt == 3'h1) begin
          // A call push leaves with src zero and no vector address set.
          state_next.st = (state_reg.vaddr != 16'h0000) ? ivs_pkg::ST_VECHI : ivs_pkg::ST_IDLE;
        end
      end
      ivs_pkg::ST_VECHI: begin
        state_next.addr = state_reg.vaddr;
        state_next.rd   = 1'b1;
        state_next.st   = ivs_pkg::ST_VECLO;
      end
      ivs_pkg::ST_VECLO: begin
        if (state_reg.rd && !state_reg.addr[0]) begin
          // Read data trails the strobe by a cycle, so the odd read goes out before the high byte lands.
          state_next.addr = state_reg.vaddr | 16'h0001;
          state_next.rd   = 1'b1;
        end else if (state_reg.rd) begin
          state_next.vhi = mem_rdata;
        end else begin
          state_next.pc    = {state_reg.vhi, mem_rdata};
          state_next.pcl   = 1'b1;
          state_next.ack   = 1'b1;
          state_next.vaddr = 16'h0000;
          state_next.st    = ivs_pkg::ST_IDLE;
        end
      end
      ivs_pkg::ST_PULL: begin
        state_next.sp   = sp_inc(state_reg.sp);
        state_next.addr = sp_inc(state_reg.sp);
        state_next.rd   = 1'b1;
        state_next.cnt  = state_reg.cnt - 3'h1;
        if (state_reg.cnt == 3'h1) begin
          state_next.st = ivs_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next.st = ivs_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg    <= '0;
      state_reg.sp <= ivs_pkg::SP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pulled return bytes and pushed register bytes flow on the core's data bus; this block only steers addresses.
  assign busy       = state_reg.st != ivs_pkg::ST_IDLE;
  assign mem_addr   = state_reg.addr;
  assign mem_wr     = state_reg.wr;
  assign mem_rd     = state_reg.rd;
  assign push_index = state_reg.cnt;
  assign stack_ptr  = state_reg.sp;
  assign new_pc     = state_reg.pc;
  assign pc_load    = state_reg.pcl;
  assign ack_index  = state_reg.src;
  assign int_ack    = state_reg.ack;
  assign ram_sel    = (cpu_addr >= ivs_pkg::RAM_LO) && (cpu_addr <= ivs_pkg::RAM_HI);
endmodule : ivs_unit
`default_nettype wire

//--- dv/ivs_monitor.sv
// Checker of the vector fetch and stack sequencing ports.
`timescale 1ns/1ps
`default_nettype none
module ivs_monitor (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        sp_load,
  input wire logic [15:0] sp_load_val,
  input wire logic [15:0] cpu_addr,
  input wire logic        busy,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_wr,
  input wire logic        mem_rd,
  input wire logic [2:0]  push_index,
  input wire logic [15:0] stack_ptr,
  input wire logic        pc_load,
  input wire logic [2:0]  ack_index,
  input wire logic        int_ack,
  input wire logic        ram_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] wr_cnt_reg;
  logic       busy_reg;
  // Writes are counted from the start of each sequence.
  always_ff @(posedge ref_clk) begin
    busy_reg   <= rst_n && busy;
    wr_cnt_reg <= !rst_n ? 3'h0 : (busy && !busy_reg) ? {2'h0, mem_wr} : wr_cnt_reg + {2'h0, mem_wr};
  end
  a_ram_window: assert property (ram_sel == (cpu_addr >= 16'h0080 && cpu_addr <= 16'h00ff))
    else $error("ram select wrong");
  a_push_down: assert property (mem_wr ##1 mem_wr |-> mem_addr == $past(mem_addr) - 16'h1)
    else $error("push address not decremented");
  a_pull_up: assert property (mem_rd ##1 mem_rd |-> mem_addr == $past(mem_addr) + 16'h1)
    else $error("read address not incremented");
  a_vec_hi_lo: assert property (mem_rd && mem_addr[15:8] == 8'hff && !$past(mem_rd)
    |-> !mem_addr[0] ##1 (mem_rd && mem_addr[0])) else $error("vector byte order wrong");
  a_vec_table: assert property (mem_rd && mem_addr[15:8] == 8'hff |-> mem_addr[7:1] inside
    {7'h7f, 7'h7e, 7'h7d, 7'h7b, 7'h7a, 7'h79, 7'h70, 7'h6f}) else $error("vector address outside map");
  a_five_pushes: assert property (int_ack |-> wr_cnt_reg == (ack_index == 3'h0 ? 3'h0 : 3'h5))
    else $error("wrong stacked byte count");
  a_sp_load: assert property (sp_load && !busy |=> stack_ptr == $past(sp_load_val))
    else $error("stack pointer load lost");
  a_ack_pulse: assert property (int_ack |-> pc_load ##1 !int_ack)
    else $error("acknowledge not a single pulse");
  a_push_at_sp: assert property (mem_wr |-> mem_addr == stack_ptr + 16'h1)
    else $error("push address not at stack pointer");
  a_push_count: assert property (mem_wr |-> push_index == $past(push_index) - 3'h1)
    else $error("push byte index not counting down");
endmodule : ivs_monitor
bind ivs_unit ivs_monitor i_ivs_monitor (.ref_clk(ref_clk), .rst_n(rst_n), .sp_load(sp_load),
  .sp_load_val(sp_load_val), .cpu_addr(cpu_addr), .busy(busy), .mem_addr(mem_addr), .mem_wr(mem_wr),
  .mem_rd(mem_rd), .push_index(push_index), .stack_ptr(stack_ptr), .pc_load(pc_load), .ack_index(ack_index),
  .int_ack(int_ack),
  .ram_sel(ram_sel));
`default_nettype wire

//--- dv/ivs_mem_model.sv
// Memory model answering core reads one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module ivs_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        mem_rd,
  input  wire logic [15:0] mem_addr,
  output var  logic [7:0]  mem_rdata
);
  initial mem_rdata = 8'h00;
  // Idle cycles show the inverted byte, so stale data never passes for an answer.
  always @(posedge ref_clk) begin
    mem_rdata <= mem_rd ? mem_addr[7:0] ^ 8'h5a : ~mem_rdata;
  end
endmodule : ivs_mem_model
`default_nettype wire

//--- dv/ivs_unit_tb_top.sv
// Self-checking bench for the vector and stack sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t bad %h", $time, a); end end
module ivs_unit_tb_top;
  logic        ref_clk = 0, rst_n = 0, int_enable = 0, call_start = 0, ret_start = 0, sp_load = 0;
  logic [7:0]  irq_req = 8'h00, mem_rdata, m;
  logic [15:0] sp_load_val = 16'h00ff, cpu_addr = 16'h0000, mem_addr, stack_ptr, new_pc, sp;
  logic        busy, mem_wr, mem_rd, pc_load, int_ack, ram_sel;
  logic [2:0]  push_index, ack_index;
  logic [18:0] notes[$], nt;
  int          num_errors = 0, comparisons = 0, seed = 32'h7ae6, n, k;
  logic [15:0] vec[8] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff6, 16'hfff4, 16'hfff2, 16'hffe0, 16'hffde};
  ivs_unit i_ivs_unit (.ref_clk(ref_clk), .rst_n(rst_n), .irq_req(irq_req), .int_enable(int_enable),
    .call_start(call_start), .ret_start(ret_start), .sp_load(sp_load), .sp_load_val(sp_load_val),
    .mem_rdata(mem_rdata), .cpu_addr(cpu_addr), .busy(busy), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .push_index(push_index), .stack_ptr(stack_ptr), .new_pc(new_pc), .pc_load(pc_load),
    .ack_index(ack_index), .int_ack(int_ack), .ram_sel(ram_sel));
  ivs_mem_model i_ivs_mem_model (.ref_clk(ref_clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cpu_addr <= #1 16'($random(seed)) & 16'h01ff;
    if (pc_load) begin
      nt = notes.pop_front();
      `CHK({ack_index, new_pc}, nt)
    end
  end
  task automatic step(input int c = 1);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic wait_idle();
    n = 0;
    while (busy !== 1'b0 && n < 40) begin step(); n++; end
    `CHK(busy, 1'b0)
  endtask : wait_idle
  task automatic load_sp(input logic [15:0] v);
    sp_load = 1; sp_load_val = v; step();
    sp_load = 0; step();
    `CHK(stack_ptr, v)
  endtask : load_sp
  task automatic irq(input logic [7:0] r, input int i);
    load_sp(16'h0085 + {10'h000, m[5:0]});
    sp = (i == 0) ? 16'h00ff : stack_ptr - 16'h5;
    notes.push_back({i[2:0], vec[i][7:0] ^ 8'h5a, vec[i][7:0] ^ 8'h5b});
    irq_req = r; int_enable = 1; n = 0;
    while (int_ack !== 1'b1 && n < 40) begin step(); n++; end
    irq_req = 8'h00;
    wait_idle();
    `CHK(stack_ptr, sp)
  endtask : irq
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #(100 * 4000); num_errors++; tally_and_finish();
  end
  initial begin
    step(12); rst_n = 1; step();
    `CHK(stack_ptr, 16'h00ff)
    for (int i = 0; i < 8; i++) begin m = 8'($random(seed)); irq(8'h01 << i, i); end
    $display("single sources done");
    repeat (12) begin
      m = 8'($random(seed)); if (m == 8'h00) m = 8'h80;
      for (int i = 7; i >= 0; i--) if (m[i]) k = i;
      irq(m, k);
    end
    $display("priority mixes done");
    int_enable = 0; irq_req = 8'h04; step(20);
    `CHK(busy, 1'b0)
    irq_req = 8'h00; load_sp(16'h00c0); call_start = 1; step(); call_start = 0; wait_idle();
    `CHK(stack_ptr, 16'h00be)
    ret_start = 1; step(); ret_start = 0; wait_idle();
    `CHK(stack_ptr, 16'h00c0)
    $display("call and return done");
    tally_and_finish();
  end
endmodule : ivs_unit_tb_top
`default_nettype wire
